// >>> verilog/ccl_classifier.sv
// Bus cycle classifier: tags each bus sample with its cycle type.
// Assumes one sample per smp_valid strobe, synchronous to clk.
`timescale 1ns/10ps
`default_nettype none

// Function
// - Fetched instructions blocked by exception start are not-executed.
// - Instruction samples get one of seven instruction cycle types.
// - Data samples get one of the listed data cycle types.
// - Streaming exit tags phase aborted; next fixup decodes it.
// - Decode at cache fetch or last stall sample after a miss.
// - Data read reported at cache hit or end of miss stall.
// - Write reported on first attempt; retries tagged as stall.
// - Cacheable read miss is still tagged cached read on fill.
// - Stall samples alternate instruction and data stall tags.
// - Data samples flag invalid bytes unless show-all is set.
// - Byte order follows jumper unless configuration overrides it.
// - Instruction samples always show all bytes.
// - Non-instruction cycles shown as 32-bit data in bus order.
// - Exception start is found from the writeback exception flag.
// - Unconfirmable instruction read at gap or end is a miss.
module ccl_classifier
  import ccl_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic smp_valid,
  input wire logic smp_phase_inst,
  input wire logic [31:0] smp_addr,
  input wire logic [31:0] smp_data,
  input wire logic [3:0] smp_byte_en,
  input wire logic smp_reset,
  input wire logic smp_stall,
  input wire logic smp_fixup,
  input wire logic smp_stream_exit,
  input wire logic smp_rd,
  input wire logic smp_wr,
  input wire logic smp_cacheable,
  input wire logic smp_cp_move,
  input wire logic smp_wr_icache_only,
  input wire logic smp_wr_dcache_only,
  input wire logic writeback_exception_flag,
  input wire logic smp_gap,
  input wire logic smp_end,
  input wire logic endian_jumper_big,
  input wire logic [1:0] cfg_endian_sel,
  input wire logic cfg_show_all,
  output logic out_valid,
  output ccl_cycle_type out_type,
  output logic out_phase_inst,
  output logic [31:0] out_addr,
  output logic [31:0] out_data,
  output logic [3:0] out_byte_valid,
  output logic out_decode,
  output ccl_vec_type out_entry
);

  // One sample is held back so the next can confirm hits and exceptions
  logic p_valid_r;
  logic p_inst_r;
  logic [31:0] p_addr_r;
  logic [31:0] p_data_r;
  logic [3:0] p_be_r;
  logic [`CCL_CTL_W-1:0] p_ctl_r;
  logic imiss_r;
  logic dmiss_r;
  logic dcach_r;
  logic wr_done_r;
  logic sabort_r;
  logic imiss_nxt;
  logic dmiss_nxt;
  logic wr_done_nxt;
  logic sabort_nxt;
  logic jumper_big_r;
  logic strap_done_r;
  logic emit;
  logic look_ok;
  logic next_stall;
  logic big_sel;
  logic [3:0] mask;
  ccl_vec_type vec;
  ccl_cycle_type type_nxt;
  logic decode_nxt;
  logic [`CCL_CTL_W-1:0] smp_ctl;

  assign smp_ctl = {smp_reset, smp_stall, smp_fixup, smp_stream_exit,
                    smp_rd, smp_wr, smp_cacheable, smp_cp_move,
                    smp_wr_icache_only, smp_wr_dcache_only};

  // Held sample leaves when a successor or an end-of-store arrives
  assign emit = p_valid_r && (smp_valid || smp_end);
  // Lookahead is meaningless across a capture gap or past the end
  assign look_ok = smp_valid && !smp_gap;
  assign next_stall = look_ok && smp_stall;

  // Jumper caught after reset release, not under the reset itself
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_done_r <= 1'b0;
      jumper_big_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      jumper_big_r <= endian_jumper_big;
    end
  end

  always_comb begin
    if (cfg_endian_sel == `CCL_END_BIG) begin
      big_sel = 1'b1;
    end else if (cfg_endian_sel == `CCL_END_LITTLE) begin
      big_sel = 1'b0;
    end else begin
      big_sel = jumper_big_r;
    end
  end

  ccl_byte_mask u_mask (
    .byte_en(p_be_r),
    .big_endian(big_sel),
    .show_all(cfg_show_all),
    .inst_phase(p_inst_r),
    .valid_mask(mask)
  );

  ccl_entry_match u_entry (
    .addr(p_addr_r),
    .vec(vec)
  );

  always_comb begin
    type_nxt = CCL_D_NONE;
    decode_nxt = 1'b0;
    imiss_nxt = imiss_r;
    dmiss_nxt = dmiss_r;
    wr_done_nxt = wr_done_r;
    sabort_nxt = sabort_r;
    if (p_inst_r) begin
      if (p_ctl_r[`CCL_C_RESET]) begin
        type_nxt = CCL_I_RESET;
        imiss_nxt = 1'b0;
        sabort_nxt = 1'b0;
      end else if (!p_ctl_r[`CCL_C_STALL] && look_ok &&
                   writeback_exception_flag) begin
        type_nxt = CCL_I_NOT_EXEC;
        imiss_nxt = 1'b0;
        sabort_nxt = 1'b0;
      end else if (p_ctl_r[`CCL_C_FIXUP]) begin
        type_nxt = CCL_FETCH_FIXUP_TAG;
        decode_nxt = sabort_r;
        sabort_nxt = 1'b0;
      end else if (p_ctl_r[`CCL_C_STALL]) begin
        if (imiss_r && !next_stall) begin
          type_nxt = CCL_I_FETCH;
          decode_nxt = 1'b1;
          imiss_nxt = 1'b0;
        end else begin
          type_nxt = CCL_I_STALL;
        end
      end else if (p_ctl_r[`CCL_C_SEXIT]) begin
        type_nxt = CCL_I_STREAM_ABORT;
        sabort_nxt = 1'b1;
      end else if (!look_ok) begin
        type_nxt = CCL_I_MISS;
      end else if (next_stall) begin
        type_nxt = CCL_I_MISS;
        imiss_nxt = 1'b1;
      end else begin
        type_nxt = CCL_I_FETCH;
        decode_nxt = 1'b1;
      end
      // A running instruction phase ends any write retry window
      if (!p_ctl_r[`CCL_C_STALL]) begin
        wr_done_nxt = 1'b0;
      end
    end else begin
      if (p_ctl_r[`CCL_C_RESET]) begin
        type_nxt = CCL_D_RESET;
        dmiss_nxt = 1'b0;
        wr_done_nxt = 1'b0;
      end else if (p_ctl_r[`CCL_C_STALL]) begin
        if (dmiss_r && !next_stall) begin
          type_nxt = dcach_r ? CCL_D_CACHED_RD
                             : CCL_D_UNCACHED_RD;
          dmiss_nxt = 1'b0;
        end else begin
          type_nxt = CCL_D_STALL;
        end
      end else if (p_ctl_r[`CCL_C_CP]) begin
        type_nxt = CCL_COPROCESSOR_MOVE_TAG;
      end else if (p_ctl_r[`CCL_C_WR]) begin
        wr_done_nxt = 1'b1;
        if (wr_done_r) begin
          type_nxt = CCL_D_STALL;
        end else if (p_ctl_r[`CCL_C_WIC]) begin
          type_nxt = CCL_D_WR_ICACHE;
        end else if (p_ctl_r[`CCL_C_WDC]) begin
          type_nxt = CCL_D_WR_DCACHE;
        end else if (p_ctl_r[`CCL_C_CACH]) begin
          type_nxt = CCL_D_CACHED_WR;
        end else begin
          type_nxt = CCL_D_UNCACHED_WR;
        end
      end else if (p_ctl_r[`CCL_C_RD]) begin
        if (next_stall) begin
          type_nxt = CCL_D_MISS;
          dmiss_nxt = 1'b1;
        end else begin
          type_nxt = p_ctl_r[`CCL_C_CACH] ? CCL_D_CACHED_RD
                                          : CCL_D_UNCACHED_RD;
        end
      end else begin
        type_nxt = CCL_D_NONE;
      end
    end
  end

  // Held sample register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      p_valid_r <= 1'b0;
      p_inst_r <= 1'b0;
      p_addr_r <= 32'h0000_0000;
      p_data_r <= 32'h0000_0000;
      p_be_r <= 4'h0;
      p_ctl_r <= '0;
    end else if (smp_valid) begin
      p_valid_r <= 1'b1;
      p_inst_r <= smp_phase_inst;
      p_addr_r <= smp_addr;
      p_data_r <= smp_data;
      p_be_r <= smp_byte_en;
      p_ctl_r <= smp_ctl;
    end else if (smp_end) begin
      p_valid_r <= 1'b0;
    end
  end

  // Miss, retry and streaming tracking; stalls need not repeat cacheability
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      imiss_r <= 1'b0;
      dmiss_r <= 1'b0;
      dcach_r <= 1'b0;
      wr_done_r <= 1'b0;
      sabort_r <= 1'b0;
    end else if (emit) begin
      imiss_r <= imiss_nxt;
      dmiss_r <= dmiss_nxt;
      dcach_r <= dmiss_r ? dcach_r : p_ctl_r[`CCL_C_CACH];
      wr_done_r <= wr_done_nxt;
      sabort_r <= sabort_nxt;
    end
  end

  // Results, one per sample in bus order
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_type <= CCL_D_NONE;
      out_phase_inst <= 1'b0;
      out_addr <= 32'h0000_0000;
      out_data <= 32'h0000_0000;
      out_byte_valid <= `CCL_MASK_NONE;
      out_decode <= 1'b0;
      out_entry <= CCL_VEC_NONE;
    end else begin
      out_valid <= emit;
      if (emit) begin
        out_type <= type_nxt;
        out_phase_inst <= p_inst_r;
        out_addr <= p_addr_r;
        out_data <= p_data_r;
        out_byte_valid <= mask;
        out_decode <= decode_nxt;
        out_entry <= decode_nxt ? vec : CCL_VEC_NONE;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_emit_aligned: assert property
    (emit |=> out_valid && out_phase_inst == $past(p_inst_r))
    else $error("result not issued one cycle after sample left");
  a_no_spurious_out: assert property (!emit |=> !out_valid)
    else $error("result issued without a sample");
  a_inst_full_bytes: assert property
    (out_valid && out_phase_inst |-> out_byte_valid == `CCL_MASK_ALL)
    else $error("instruction sample has masked bytes");
  a_show_all_data: assert property
    ($past(emit && cfg_show_all) |-> out_byte_valid == `CCL_MASK_ALL)
    else $error("show-all override ignored");
  a_inst_type_set: assert property
    (out_valid && out_phase_inst |-> out_type inside {CCL_I_RESET,
     CCL_I_MISS, CCL_FETCH_FIXUP_TAG, CCL_I_STALL, CCL_I_NOT_EXEC,
     CCL_I_STREAM_ABORT, CCL_I_FETCH})
    else $error("instruction sample has a data type");
  a_data_type_set: assert property
    (out_valid && !out_phase_inst |-> !(out_type inside {CCL_I_RESET,
     CCL_I_MISS, CCL_FETCH_FIXUP_TAG, CCL_I_STALL, CCL_I_NOT_EXEC,
     CCL_I_STREAM_ABORT, CCL_I_FETCH}) && !out_decode)
    else $error("data sample has an instruction type");
  a_not_exec_tag: assert property
    (emit && p_inst_r && !p_ctl_r[`CCL_C_RESET] && !p_ctl_r[`CCL_C_STALL]
     && smp_valid && !smp_gap && writeback_exception_flag
     |=> out_type == CCL_I_NOT_EXEC && !out_decode)
    else $error("blocked instruction not tagged not-executed");
  a_end_is_miss: assert property
    (emit && !smp_valid && p_inst_r && p_ctl_r == '0
     |=> out_type == CCL_I_MISS)
    else $error("unconfirmed fetch not tagged miss");
  a_write_once: assert property
    (out_valid && out_type inside {CCL_D_CACHED_WR, CCL_D_UNCACHED_WR,
     CCL_D_WR_ICACHE, CCL_D_WR_DCACHE} |-> wr_done_r && !$past(wr_done_r))
    else $error("write reported while retry window open");
  a_stream_abort: assert property
    (out_valid && out_type == CCL_I_STREAM_ABORT |-> sabort_r && !out_decode)
    else $error("streaming abort mis-tagged");
  a_stall_phase: assert property
    (out_valid && out_type == CCL_I_STALL |-> out_phase_inst)
    else $error("stall tag on wrong phase");
  c_miss_decode: cover property
    (out_valid && out_type == CCL_I_MISS ##[1:40]
     out_valid && out_type == CCL_I_FETCH && out_decode);
  c_not_exec: cover property (out_valid && out_type == CCL_I_NOT_EXEC);
  c_write_retry: cover property
    (out_valid && out_type == CCL_D_UNCACHED_WR ##[1:20]
     out_valid && out_type == CCL_D_STALL);
  c_fixup_decode: cover property
    (out_valid && out_type == CCL_FETCH_FIXUP_TAG && out_decode);
endmodule

`default_nettype wire

// >>> verilog/ccl_consts.svh
// Constants for the bus cycle classifier: entry addresses, codes, fields.
// Assumes inclusion by bare name from the package file.
`ifndef CCL_CONSTS_SVH
`define CCL_CONSTS_SVH

// Physical exception entry points
`define CCL_ENT_RESET 32'h1fc0_0000
`define CCL_ENT_USER_TRANSLATION_MISS_B1 32'h1fc0_0100
`define CCL_ENT_USER_TRANSLATION_MISS_B0 32'h0000_0000
`define CCL_ENT_GEN_B1 32'h1fc0_0180
`define CCL_ENT_GEN_B0 32'h0000_0080

// Byte-order selection codes
`define CCL_END_JUMPER 2'h0
`define CCL_END_BIG 2'h1
`define CCL_END_LITTLE 2'h2

`define CCL_MASK_ALL 4'hf
`define CCL_MASK_NONE 4'h0

// Control vector of one held sample
`define CCL_CTL_W 10
`define CCL_C_RESET 9
`define CCL_C_STALL 8
`define CCL_C_FIXUP 7
`define CCL_C_SEXIT 6
`define CCL_C_RD 5
`define CCL_C_WR 4
`define CCL_C_CACH 3
`define CCL_C_CP 2
`define CCL_C_WIC 1
`define CCL_C_WDC 0

`endif

// >>> verilog/ccl_pkg.sv
// Types shared by the bus cycle classifier files.
// Assumes ccl_consts.svh is on the include path.
`include "ccl_consts.svh"

package ccl_pkg;

  typedef enum logic [4:0] {
    CCL_I_RESET,
    CCL_I_MISS,
    CCL_FETCH_FIXUP_TAG,
    CCL_I_STALL,
    CCL_I_NOT_EXEC,
    CCL_I_STREAM_ABORT,
    CCL_I_FETCH,
    CCL_D_RESET,
    CCL_D_NONE,
    CCL_D_MISS,
    CCL_COPROCESSOR_MOVE_TAG,
    CCL_D_CACHED_RD,
    CCL_D_UNCACHED_RD,
    CCL_D_CACHED_WR,
    CCL_D_UNCACHED_WR,
    CCL_D_WR_ICACHE,
    CCL_D_WR_DCACHE,
    CCL_D_STALL
  } ccl_cycle_type;

  typedef enum logic [2:0] {
    CCL_VEC_NONE,
    CCL_VEC_RESET,
    CCL_VEC_USER_TRANSLATION_MISS_B1,
    CCL_VEC_USER_TRANSLATION_MISS_B0,
    CCL_VEC_GEN_B1,
    CCL_VEC_GEN_B0
  } ccl_vec_type;

endpackage

// >>> verilog/ccl_byte_mask.sv
// Byte-valid mask for one sample from byte enables and byte order.
// Assumes enables are numbered by logical byte, active high.
`timescale 1ns/10ps
`default_nettype none

module ccl_byte_mask (
  input wire logic [3:0] byte_en,
  input wire logic big_endian,
  input wire logic show_all,
  input wire logic inst_phase,
  output logic [3:0] valid_mask
);

  logic [3:0] lane_mask;

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_lane
      // Big order puts logical byte 0 on the top lane
      assign lane_mask[i] = big_endian ? byte_en[3-i] : byte_en[i];
    end
  endgenerate

  // Instruction words are never masked
  assign valid_mask = (inst_phase || show_all) ? `CCL_MASK_ALL : lane_mask;

endmodule

`default_nettype wire

// >>> verilog/ccl_entry_match.sv
// Recognises fetches from the fixed exception entry points.
// Assumes physical fetch addresses on the bus.
`timescale 1ns/10ps
`default_nettype none

module ccl_entry_match
  import ccl_pkg::*;
(
  input wire logic [31:0] addr,
  output ccl_vec_type vec
);

  always_comb begin
    if (addr == `CCL_ENT_RESET) begin
      vec = CCL_VEC_RESET;
    end else if (addr == `CCL_ENT_USER_TRANSLATION_MISS_B1) begin
      vec = CCL_VEC_USER_TRANSLATION_MISS_B1;
    end else if (addr == `CCL_ENT_USER_TRANSLATION_MISS_B0) begin
      vec = CCL_VEC_USER_TRANSLATION_MISS_B0;
    end else if (addr == `CCL_ENT_GEN_B1) begin
      vec = CCL_VEC_GEN_B1;
    end else if (addr == `CCL_ENT_GEN_B0) begin
      vec = CCL_VEC_GEN_B0;
    end else begin
      vec = CCL_VEC_NONE;
    end
  end

endmodule

`default_nettype wire

// >>> testbench/ccl_cpu_model.sv
// Processor bus model: presents one bus sample per clock to the classifier.
// Assumes the bench calls its tasks; flag bit 11 exception, 10 gap, 9..0
// follow the classifier control vector.
`timescale 1ns/10ps
`default_nettype none

module ccl_cpu_model (
  input wire logic clk,
  output logic smp_valid,
  output logic smp_phase_inst,
  output logic [31:0] smp_addr,
  output logic [31:0] smp_data,
  output logic [3:0] smp_byte_en,
  output logic [11:0] smp_flags,
  output logic smp_end
);
  initial begin
    smp_valid = 1'b0;
    smp_phase_inst = 1'b0;
    smp_addr = 32'h0;
    smp_data = 32'h0;
    smp_byte_en = 4'h0;
    smp_flags = 12'h0;
    smp_end = 1'b0;
  end

  task automatic put(input logic inst, input logic [31:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     input logic [11:0] f);
    @(posedge clk);
    smp_valid <= 1'b1;
    smp_phase_inst <= inst;
    smp_addr <= a;
    smp_data <= d;
    smp_byte_en <= be;
    smp_flags <= f;
    smp_end <= 1'b0;
  endtask

  // Released bus must not look like a held value
  task automatic idle(input logic fin);
    @(posedge clk);
    smp_valid <= 1'b0;
    smp_end <= fin;
    smp_addr <= ~smp_addr;
    smp_data <= ~smp_data;
    smp_byte_en <= ~smp_byte_en;
    smp_flags <= 12'h0;
  endtask

  task automatic stall(input logic [31:0] a, input int n);
    repeat (n) begin
      put(1'b0, a, 32'h0, 4'hf, 12'h100);
      put(1'b1, a, 32'h0, 4'hf, 12'h100);
    end
  endtask

  // No vector cycle: entry shows only as a fetch from a fixed address
  task automatic enter(input logic bev, input logic user_translation_miss);
    logic [31:0] a;
    a = user_translation_miss ? 32'h0000_0000 : 32'h0000_0080;
    if (bev) begin
      a = user_translation_miss ? 32'h1fc0_0100 : 32'h1fc0_0180;
    end
    put(1'b1, a, 32'h2400_0000, 4'hf, 12'h0);
  endtask
endmodule
`default_nettype wire

// >>> testbench/ccl_classifier_bench.sv
// Bench for the bus cycle classifier: each scenario drives the bus model
// and compares every classified sample, except those sc_reset drops at reset, with its expected cycle type.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end

module ccl_classifier_bench
  import ccl_pkg::*;
;
  typedef struct packed {
    ccl_cycle_type kind;
    logic [3:0] mask;
    logic dec;
    ccl_vec_type vec;
    logic [31:0] data;
    logic ph;
    logic [31:0] adr;
  } ccl_res_type;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic jumper_big = 1'b1;
  logic [1:0] endian_sel = 2'h0;
  logic show_all = 1'b0;
  logic valid, phase, fin;
  logic [31:0] addr, data, o_data, o_addr;
  logic [3:0] be, o_mask;
  logic [11:0] fl;
  logic o_valid, o_dec, o_ph;
  ccl_cycle_type o_type;
  ccl_vec_type o_vec;
  ccl_res_type res_q[$];
  ccl_res_type last;
  int fails = 0;
  int n_checks = 0;

  always #12.5 clk = ~clk;

  ccl_cpu_model cpu (.clk(clk), .smp_valid(valid), .smp_phase_inst(phase),
    .smp_addr(addr), .smp_data(data), .smp_byte_en(be), .smp_flags(fl),
    .smp_end(fin));

  ccl_classifier uut (.clk(clk), .arst_n(arst_n), .smp_valid(valid),
    .smp_phase_inst(phase), .smp_addr(addr), .smp_data(data),
    .smp_byte_en(be), .smp_reset(fl[9]), .smp_stall(fl[8]),
    .smp_fixup(fl[7]), .smp_stream_exit(fl[6]), .smp_rd(fl[5]),
    .smp_wr(fl[4]), .smp_cacheable(fl[3]), .smp_cp_move(fl[2]),
    .smp_wr_icache_only(fl[1]), .smp_wr_dcache_only(fl[0]),
    .writeback_exception_flag(fl[11]), .smp_gap(fl[10]), .smp_end(fin),
    .endian_jumper_big(jumper_big), .cfg_endian_sel(endian_sel),
    .cfg_show_all(show_all), .out_valid(o_valid), .out_type(o_type),
    .out_phase_inst(o_ph), .out_addr(o_addr), .out_data(o_data),
    .out_byte_valid(o_mask), .out_decode(o_dec), .out_entry(o_vec));

  // Sampled mid-cycle, away from the edge that launches results
  always @(negedge clk) begin
    if (o_valid === 1'b1) begin
      res_q.push_back('{o_type, o_mask, o_dec, o_vec, o_data, o_ph, o_addr});
    end
  end

  task automatic end_sim();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Decode check skipped when dc is x
  task automatic expect_r(input ccl_cycle_type t, input logic [3:0] m,
                          input logic dc);
    int n;
    n = 0;
    while (res_q.size() == 0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (res_q.size() == 0) begin
      fails++;
      $display("CHECK FAILED %0t no result", $time);
      end_sim();
    end else begin
      last = res_q.pop_front();
      `CHK(last.kind, t)
      `CHK(last.mask, m)
      // Instruction types precede data types in the enum
      `CHK(last.ph, t < CCL_D_RESET)
      if (dc !== 1'bx) `CHK(last.dec, dc)
    end
  endtask

  task automatic fetch(input logic [31:0] a);
    cpu.put(1'b1, a, 32'h2400_0000, 4'h0, 12'h0);
  endtask

  task automatic dat(input logic [11:0] f);
    cpu.put(1'b0, 32'h0001_4010, 32'h7654_3210, 4'hf, f);
  endtask

  task automatic flush();
    cpu.idle(1'b1);
    cpu.idle(1'b0);
  endtask

  task automatic sc_types();
    logic [11:0] fv[8] = '{12'h028, 12'h020, 12'h018, 12'h010,
                           12'h004, 12'h012, 12'h011, 12'h200};
    ccl_cycle_type ex[8] = '{CCL_D_CACHED_RD, CCL_D_UNCACHED_RD,
      CCL_D_CACHED_WR, CCL_D_UNCACHED_WR, CCL_COPROCESSOR_MOVE_TAG,
      CCL_D_WR_ICACHE, CCL_D_WR_DCACHE, CCL_D_RESET};
    foreach (fv[i]) begin
      fetch(32'h0040_0000);
      dat(fv[i]);
      fetch(32'h0040_0004);
      flush();
      expect_r(CCL_I_FETCH, 4'hf, 1'b1);
      expect_r(ex[i], 4'hf, 1'bx);
      `CHK(last.data, 32'h7654_3210)
      `CHK(last.adr, 32'h0001_4010)
      expect_r(CCL_I_MISS, 4'hf, 1'bx);
    end
    cpu.put(1'b1, 32'h1fc0_0000, 32'h0, 4'h0, 12'h200);
    flush();
    expect_r(CCL_I_RESET, 4'hf, 1'bx);
  endtask

  task automatic sc_entry();
    ccl_vec_type ev[4] = '{CCL_VEC_GEN_B0, CCL_VEC_GEN_B1,
                           CCL_VEC_USER_TRANSLATION_MISS_B0, CCL_VEC_USER_TRANSLATION_MISS_B1};
    for (int i = 0; i < 4; i++) begin
      fetch(32'h0040_0020);
      dat(12'h800);
      cpu.enter(i[0], i[1]);
      dat(12'h0);
      flush();
      expect_r(CCL_I_NOT_EXEC, 4'hf, 1'bx);
      expect_r(CCL_D_NONE, 4'hf, 1'bx);
      expect_r(CCL_I_FETCH, 4'hf, 1'b1);
      `CHK(last.vec, ev[i])
      expect_r(CCL_D_NONE, 4'hf, 1'bx);
    end
  endtask

  task automatic sc_stream_miss();
    fetch(32'h0040_0030);
    cpu.put(1'b1, 32'h0040_0034, 32'h0, 4'h0, 12'h040);
    dat(12'h0);
    cpu.put(1'b1, 32'h0040_0034, 32'h0, 4'h0, 12'h080);
    dat(12'h0);
    flush();
    expect_r(CCL_I_FETCH, 4'hf, 1'b1);
    expect_r(CCL_I_STREAM_ABORT, 4'hf, 1'b0);
    expect_r(CCL_D_NONE, 4'hf, 1'bx);
    expect_r(CCL_FETCH_FIXUP_TAG, 4'hf, 1'b1);
    expect_r(CCL_D_NONE, 4'hf, 1'bx);
    fetch(32'h0041_4950);
    cpu.stall(32'h0041_4950, 2);
    dat(12'h028);
    fetch(32'h0041_4954);
    flush();
    expect_r(CCL_I_MISS, 4'hf, 1'bx);
    expect_r(CCL_D_STALL, 4'hf, 1'bx);
    expect_r(CCL_I_STALL, 4'hf, 1'b0);
    expect_r(CCL_D_STALL, 4'hf, 1'bx);
    expect_r(CCL_I_FETCH, 4'hf, 1'b1);
    expect_r(CCL_D_CACHED_RD, 4'hf, 1'bx);
    expect_r(CCL_I_MISS, 4'hf, 1'bx);
  endtask

  task automatic sc_read_write();
    fetch(32'h0041_4960);
    dat(12'h028);
    cpu.put(1'b1, 32'h0041_4964, 32'h0, 4'h0, 12'h100);
    dat(12'h100);
    fetch(32'h0041_4964);
    dat(12'h010);
    dat(12'h010);
    fetch(32'h0041_4968);
    dat(12'h400);
    flush();
    expect_r(CCL_I_FETCH, 4'hf, 1'b1);
    expect_r(CCL_D_MISS, 4'hf, 1'bx);
    expect_r(CCL_I_STALL, 4'hf, 1'b0);
    expect_r(CCL_D_CACHED_RD, 4'hf, 1'bx);
    expect_r(CCL_I_FETCH, 4'hf, 1'b1);
    expect_r(CCL_D_UNCACHED_WR, 4'hf, 1'bx);
    expect_r(CCL_D_STALL, 4'hf, 1'bx);
    expect_r(CCL_I_MISS, 4'hf, 1'bx);
    expect_r(CCL_D_NONE, 4'hf, 1'bx);
  endtask

  task automatic sc_bytes();
    logic [3:0] em[5] = '{4'hc, 4'hc, 4'h3, 4'hc, 4'hf};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      endian_sel <= i[1:0];
      show_all <= (i == 4);
      fetch(32'h0040_0040);
      cpu.put(1'b0, 32'h0001_4010, 32'h7654_3210, 4'h3, 12'h020);
      flush();
      expect_r(CCL_I_FETCH, 4'hf, 1'b1);
      expect_r(CCL_D_UNCACHED_RD, em[i], 1'bx);
      `CHK(last.data, 32'h7654_3210)
    end
  endtask

  task automatic sc_reset();
    fetch(32'h0040_0050);
    cpu.stall(32'h0040_0050, 1);
    cpu.idle(1'b0);
    arst_n <= 1'b0;
    // Jumper low now, captured again after release
    jumper_big <= 1'b0;
    endian_sel <= 2'h0;
    show_all <= 1'b0;
    @(negedge clk);
    `CHK(o_valid, 1'b0)
    `CHK(o_type, CCL_D_NONE)
    @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    res_q.delete();
    // A kept miss would turn this stall into a decoded fetch
    cpu.put(1'b1, 32'h0040_0054, 32'h0, 4'h0, 12'h100);
    cpu.put(1'b0, 32'h0001_4010, 32'h7654_3210, 4'h3, 12'h020);
    flush();
    expect_r(CCL_I_STALL, 4'hf, 1'b0);
    expect_r(CCL_D_UNCACHED_RD, 4'h3, 1'bx);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    sc_types();
    sc_entry();
    sc_stream_miss();
    sc_read_write();
    sc_bytes();
    sc_reset();
    end_sim();
  end
endmodule
`default_nettype wire
